// *** rtl/cfp_ctrl.sv ***
/*
  Code flash program/erase controller with firmware and serial request ports.
  Assumes one 10 MHz clock; array held in flip-flops; firmware ports are registers.
*/
// What this block does
// - Four sectors of 256, pages of 16
// - Byte granular read, write and erase
// - Sector erase and page erase supported
// - Chip erase clears whole array
// - Page buffer programs one to sixteen bytes
// - Internal timing, every operation within 2 ms
// - No direct readback through programming ports
// - CRC-32 over sector or whole array
// - Code reads refused for secured sectors
// - Four security bytes, one per sector
// - Firmware uses control, data, two address registers
// - Config byte, boot status, vector reprogrammable
// - Power-up config latched, fixed after start
// - Serial three-wire port (clock, data, frame) accepts requests
// - Firmware, serial, parallel routes all work
`timescale 1ns/1ps
module cfp_ctrl #(
  parameter int unsigned OP_CYCLES = cfp_pkg::OP_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  fw_ctrl,
  input  wire logic        fw_ctrl_wr,
  input  wire logic [7:0]  fw_data,
  input  wire logic [7:0]  fw_addr_hi,
  input  wire logic [7:0]  fw_addr_lo,
  input  wire logic        par_mode,
  input  wire logic        sclk,
  input  wire logic        sdata_in,
  input  wire logic        frame_n,
  input  wire logic [9:0]  code_addr,
  input  wire logic        code_rd,
  output logic [7:0]       code_data,
  output logic             code_refused,
  output logic             busy,
  output logic             op_done,
  output logic [31:0]      crc_result,
  output logic [7:0]       power_up_config_byte,
  output logic             boot_status,
  output logic [7:0]       boot_vector
);
  typedef enum {ST_IDLE, ST_WORK, ST_CRC, ST_WAIT} cfp_state_e;

  // Internal reset released through two flip-flops.
  logic [1:0] rst_sy;
  logic       rst_i_n;
  // Array, page buffer with load marks, configuration bytes.
  logic [7:0] mem [cfp_pkg::ARRAY_BYTES];
  logic [7:0] pbuf [cfp_pkg::PAGE_BYTES];
  logic [cfp_pkg::PAGE_BYTES-1:0] pmark, next_pmark;
  logic [7:0] cfg_ucfg, cfg_bvec;
  logic       cfg_bstat;
  logic [cfp_pkg::SECTORS-1:0] sec, next_sec;
  logic [7:0] next_cfg_ucfg, next_cfg_bvec;
  logic       next_cfg_bstat;
  logic       ucfg_loaded;
  // Sequencer state.
  cfp_state_e state, next_state;
  cfp_pkg::cfp_req_s cur, next_cur, fw_req, ser_req, sel_req;
  logic       ser_valid, sel_valid;
  logic [cfp_pkg::ADDR_W-1:0] idx, next_idx, last, next_last;
  logic [cfp_pkg::TMR_W-1:0]  tmr, next_tmr;
  logic [31:0] crc, next_crc;
  logic        next_done;

  // Reset synchroniser.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sy <= 2'h0;
    end else begin
      rst_sy <= {rst_sy[0], 1'b1};
    end
  end
  assign rst_i_n = rst_sy[1];

  // Serial programming port receiver.
  cfp_ser_rx u_ser (
    .clk      (clk),
    .rst_n    (rst_i_n),
    .sclk     (sclk),
    .sdata_in (sdata_in),
    .frame_n  (frame_n),
    .req      (ser_req),
    .req_valid(ser_valid)
  );

  // Firmware request from the control, data and two address registers.
  assign fw_req = '{op: cfp_pkg::cfp_op_e'(fw_ctrl[3:0]),
                    addr: {fw_addr_hi[1:0], fw_addr_lo}, data: fw_data};
  // Serial wins a collision; parallel mode uses the same firmware-style ports.
  assign sel_valid = ser_valid | fw_ctrl_wr;
  assign sel_req   = ser_valid ? ser_req : fw_req;

  // One CRC-32 byte step, MSB first.
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[31] ^ d[i]) ? ((r << 1) ^ cfp_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_step

  // Sector of an address.
  function automatic logic [1:0] sect_of(input logic [cfp_pkg::ADDR_W-1:0] a);
    return a[cfp_pkg::ADDR_W-1:cfp_pkg::SECT_POS];
  endfunction : sect_of

  // Sequencer next state: accepts requests only in idle, runs self-timed.
  always_comb begin
    next_state = state;
    next_cur   = cur;
    next_idx   = idx;
    next_last  = last;
    next_tmr   = tmr;
    next_crc   = crc;
    next_pmark = pmark;
    next_done  = 1'b0;
    next_sec   = sec;
    next_cfg_ucfg  = cfg_ucfg;
    next_cfg_bstat = cfg_bstat;
    next_cfg_bvec  = cfg_bvec;
    case (state)
      ST_IDLE: begin
        if (sel_valid) begin
          next_cur = sel_req;
          next_tmr = '0;
          if (sel_req.op == cfp_pkg::CFP_OP_LOAD) begin
            // Loading the page buffer needs no timing.
            next_pmark[sel_req.addr[cfp_pkg::PAGE_IDX_W-1:0]] = 1'b1;
          end else if (sel_req.op == cfp_pkg::CFP_OP_CRC_SECT) begin
            next_idx   = {sel_req.addr[9:8], 8'h00};
            next_last  = {sel_req.addr[9:8], 8'hff};
            next_crc   = cfp_pkg::CRC_SEED;
            next_state = ST_CRC;
          end else if (sel_req.op == cfp_pkg::CFP_OP_CRC_ALL) begin
            next_idx   = '0;
            next_last  = '1;
            next_crc   = cfp_pkg::CRC_SEED;
            next_state = ST_CRC;
          end else if (sel_req.op != cfp_pkg::CFP_OP_NONE &&
                       sel_req.op != cfp_pkg::CFP_OP_READ) begin
            // Reads on the programming ports are dropped: no readback path.
            next_state = ST_WORK;
          end
        end
      end
      ST_WORK: begin
        // Config byte, boot status and vector writes take effect in nonvolatile copies only; security bits act on code reads at once.
        if (cur.op == cfp_pkg::CFP_OP_PROG_CFG || cur.op == cfp_pkg::CFP_OP_ERASE_CFG) begin
          if (cur.addr[2:0] == cfp_pkg::CFG_UCFG) begin
            next_cfg_ucfg = (cur.op == cfp_pkg::CFP_OP_ERASE_CFG) ? cfp_pkg::ERASED
                            : cfg_ucfg & cur.data;
          end else if (cur.addr[2:0] == cfp_pkg::CFG_BSTAT) begin
            next_cfg_bstat = (cur.op == cfp_pkg::CFP_OP_ERASE_CFG) | (cfg_bstat & cur.data[0]);
          end else if (cur.addr[2:0] == cfp_pkg::CFG_BVEC) begin
            next_cfg_bvec = (cur.op == cfp_pkg::CFP_OP_ERASE_CFG) ? cfp_pkg::ERASED
                            : cfg_bvec & cur.data;
          end else if (cur.addr[2]) begin
            // Security bits: programming sets one sector's protection.
            next_sec[cur.addr[1:0]] = (cur.op == cfp_pkg::CFP_OP_PROG_CFG);
          end
        end
        if (cur.op == cfp_pkg::CFP_OP_PROG_PAGE) begin
          next_pmark = '0;
        end
        next_state = ST_WAIT;
      end
      ST_CRC: begin
        next_crc = crc_step(crc, mem[idx]);
        next_idx = idx + 10'h001;
        next_tmr = tmr + 1'b1;
        if (idx == last) begin
          next_state = ST_IDLE;
          next_done  = 1'b1;
        end
      end
      default: begin
        // Internal pulse timer bounds every program, erase and configuration operation to the budget.
        next_tmr = tmr + 1'b1;
        if (tmr >= cfp_pkg::TMR_W'(OP_CYCLES - 2)) begin
          next_state = ST_IDLE;
          next_done  = 1'b1;
        end
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      state      <= ST_IDLE;
      cur        <= '0;
      idx        <= '0;
      last       <= '0;
      tmr        <= '0;
      crc        <= '0;
      pmark      <= '0;
      op_done    <= 1'b0;
      crc_result <= '0;
      sec        <= '0;
      cfg_ucfg   <= cfp_pkg::ERASED;
      cfg_bstat  <= 1'b1;
      cfg_bvec   <= cfp_pkg::ERASED;
    end else begin
      state      <= next_state;
      cur        <= next_cur;
      idx        <= next_idx;
      last       <= next_last;
      tmr        <= next_tmr;
      crc        <= next_crc;
      pmark      <= next_pmark;
      op_done    <= next_done;
      crc_result <= (next_done && state == ST_CRC) ? next_crc : crc_result;
      sec        <= next_sec;
      cfg_ucfg   <= next_cfg_ucfg;
      cfg_bstat  <= next_cfg_bstat;
      cfg_bvec   <= next_cfg_bvec;
    end
  end

  // Page buffer capture on load requests, restricted to one page by the requester.
  always_ff @(posedge clk) begin
    if (state == ST_IDLE && sel_valid && sel_req.op == cfp_pkg::CFP_OP_LOAD) begin
      pbuf[sel_req.addr[cfp_pkg::PAGE_IDX_W-1:0]] <= sel_req.data;
    end
  end

  // Array update, one generate slice per byte, applied in the work cycle.
  for (genvar g = 0; g < cfp_pkg::ARRAY_BYTES; g++) begin : g_byte
    logic [7:0] next_b;
    localparam logic [9:0] GA = 10'(g);
    always_comb begin
      next_b = mem[g];
      if (state == ST_WORK) begin
        case (cur.op)
          cfp_pkg::CFP_OP_ERASE_BYTE:
            if (cur.addr == GA) next_b = cfp_pkg::ERASED;
          cfp_pkg::CFP_OP_ERASE_PAGE:
            if (cur.addr[9:4] == GA[9:4]) next_b = cfp_pkg::ERASED;
          cfp_pkg::CFP_OP_ERASE_SECT:
            if (sect_of(cur.addr) == sect_of(GA)) next_b = cfp_pkg::ERASED;
          cfp_pkg::CFP_OP_ERASE_CHIP:
            next_b = cfp_pkg::ERASED;
          cfp_pkg::CFP_OP_PROG_PAGE:
            if (cur.addr[9:4] == GA[9:4] && pmark[g % cfp_pkg::PAGE_BYTES])
              next_b = mem[g] & pbuf[g % cfp_pkg::PAGE_BYTES];
          default: next_b = mem[g];
        endcase
      end
    end
    always_ff @(posedge clk) begin
      mem[g] <= next_b;
    end
  end

  // Power-up configuration snapshot, taken once after reset release.
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      ucfg_loaded          <= 1'b0;
      power_up_config_byte <= '0;
      boot_status          <= 1'b0;
      boot_vector          <= '0;
    end else if (!ucfg_loaded) begin
      ucfg_loaded          <= 1'b1;
      power_up_config_byte <= cfg_ucfg;
      boot_status          <= cfg_bstat;
      boot_vector          <= cfg_bvec;
    end
  end

  // Code-space reads, refused for secured sectors.
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      code_data    <= '0;
      code_refused <= 1'b0;
    end else if (code_rd) begin
      code_refused <= sec[sect_of(code_addr)] | par_mode;
      // Any refused read, secured sector or parallel mode, returns zero.
      code_data    <= (sec[sect_of(code_addr)] | par_mode) ? 8'h00 : mem[code_addr];
    end
  end

  assign busy = (state != ST_IDLE);
endmodule : cfp_ctrl

// *** rtl/cfp_pkg.sv ***
/*
  Shared constants and carrier types for the code flash program/erase controller.
  Assumes a 10 MHz system clock and a byte-wide flash array model kept in flip-flops.
*/
package cfp_pkg;
  // Array geometry.
  localparam int unsigned SECTORS      = 4;
  localparam int unsigned SECTOR_BYTES = 256;
  localparam int unsigned PAGE_BYTES   = 16;
  localparam int unsigned ARRAY_BYTES  = SECTORS * SECTOR_BYTES;
  localparam int unsigned ADDR_W       = 10;
  localparam int unsigned PAGE_IDX_W   = 4;
  localparam int unsigned SECT_POS     = 8;
  localparam int unsigned PAGE_POS     = 4;
  // Erased state of a byte.
  localparam logic [7:0]  ERASED       = 8'hff;
  // Timing: the operation budget and clock rate.
  localparam int unsigned OP_TIME_US   = 2000;
  localparam int unsigned CLK_MHZ      = 10;
  localparam int unsigned OP_CYCLES    = OP_TIME_US * CLK_MHZ;
  localparam int unsigned TMR_W        = 15;
  // CRC-32 polynomial and seed.
  localparam logic [31:0] CRC_POLY     = 32'h04c11db7;
  localparam logic [31:0] CRC_SEED     = 32'hffffffff;
  // Serial port frame widths.
  localparam int unsigned SER_CMD_W    = 4;
  localparam int unsigned SER_FRAME_W  = 22;

  // Operation codes shared by firmware and serial port.
  typedef enum logic [3:0] {
    CFP_OP_NONE, CFP_OP_LOAD, CFP_OP_PROG_PAGE, CFP_OP_ERASE_BYTE, CFP_OP_ERASE_PAGE,
    CFP_OP_ERASE_SECT, CFP_OP_ERASE_CHIP, CFP_OP_CRC_SECT, CFP_OP_CRC_ALL,
    CFP_OP_READ, CFP_OP_PROG_CFG, CFP_OP_ERASE_CFG
  } cfp_op_e;

  // Configuration targets: power-up config, boot status, boot vector, security bytes.
  localparam logic [2:0] CFG_UCFG   = 3'h0;
  localparam logic [2:0] CFG_BSTAT  = 3'h1;
  localparam logic [2:0] CFG_BVEC   = 3'h2;
  localparam logic [2:0] CFG_SEC0   = 3'h4;

  // One request: operation, address, data.
  typedef struct packed {
    cfp_op_e           op;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } cfp_req_s;
endpackage : cfp_pkg

// *** rtl/cfp_ser_rx.sv ***
/*
  Serial programming port receiver: shifts frames on the serial clock pin.
  Assumes sclk and sdata come from outside and are synchronised here.
*/
`timescale 1ns/1ps
module cfp_ser_rx (
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire logic     sclk,
  input  wire logic     sdata_in,
  input  wire logic     frame_n,
  output cfp_pkg::cfp_req_s req,
  output logic          req_valid
);
  // Three-stage synchronisers for each pin.
  logic [2:0] sclk_sy;
  logic [2:0] sdat_sy;
  logic [2:0] frm_sy;
  logic [cfp_pkg::SER_FRAME_W-1:0] shreg, next_shreg;
  logic [4:0] cnt, next_cnt;
  cfp_pkg::cfp_req_s next_req;
  logic next_valid;
  logic rise;
  logic sclk_lvl, next_lvl; // Accepted serial clock level.

  // A change counts once the second and third stages agree.
  assign rise = sclk_sy[2] & sclk_sy[1] & ~sclk_lvl;

  // Shifts in bits on each rising serial clock while the frame is low.
  always_comb begin
    next_shreg = shreg;
    next_cnt   = cnt;
    next_req   = req;
    next_valid = 1'b0;
    next_lvl   = sclk_lvl;
    // The accepted level follows the pin only when two stages agree.
    if (sclk_sy[2] == sclk_sy[1]) begin
      next_lvl = sclk_sy[2];
    end
    if (frm_sy[2] & frm_sy[1]) begin
      // Frame idle: restart the bit count.
      next_cnt = '0;
    end else if (rise) begin
      next_shreg = {shreg[cfp_pkg::SER_FRAME_W-2:0], sdat_sy[2]};
      next_cnt   = cnt + 5'h01;
      if (cnt == 5'(cfp_pkg::SER_FRAME_W - 1)) begin
        next_req   = cfp_pkg::cfp_req_s'({shreg[cfp_pkg::SER_FRAME_W-2:0], sdat_sy[2]});
        next_valid = 1'b1;
        next_cnt   = '0;
      end
    end
  end

  // Registers the synchronisers and the shifter.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sy   <= '0;
      sdat_sy   <= '0;
      frm_sy    <= 3'h7;
      sclk_lvl  <= 1'b0;
      shreg     <= '0;
      cnt       <= '0;
      req       <= '0;
      req_valid <= 1'b0;
    end else begin
      sclk_sy   <= {sclk_sy[1:0], sclk};
      sdat_sy   <= {sdat_sy[1:0], sdata_in};
      frm_sy    <= {frm_sy[1:0], frame_n};
      sclk_lvl  <= next_lvl;
      shreg     <= next_shreg;
      cnt       <= next_cnt;
      req       <= next_req;
      req_valid <= next_valid;
    end
  end
endmodule : cfp_ser_rx

// *** verification/cfp_ser_prog.sv ***
/*
  Behavioural serial programmer that drives the three-wire programming port (clock, data, frame).
  Assumes the bench calls send with whole request frames, one at a time.
*/
`timescale 1ns/1ps
module cfp_ser_prog (
  output logic sclk,
  output logic sdata_in,
  output logic frame_n
);
  // The clock idles low and the frame stays closed outside a transfer.
  initial begin
    sclk     = 1'b0;
    sdata_in = 1'b0;
    frame_n  = 1'b1;
  end
  // Shifts one request MSB first; data settles half a bit before each rise.
  task automatic send(input cfp_pkg::cfp_req_s r);
    logic [21:0] f;
    f = r;
    frame_n = 1'b0;
    for (int i = 21; i >= 0; i--) begin
      sdata_in = f[i];
      #400;
      sclk = 1'b1;
      #400;
      sclk = 1'b0;
    end
    #400;
    frame_n  = 1'b1;
    sdata_in = ~sdata_in;
    // Keep the frame closed long enough to be seen before the next one.
    #400;
  endtask : send
endmodule : cfp_ser_prog

// *** verification/cfp_ctrl_assertions.sv ***
/*
  Port-level checker for the code flash controller.
  Assumes it is bound to cfp_ctrl and sees only that module's ports.
*/
`timescale 1ns/1ps
module cfp_ctrl_assertions #(
  parameter int unsigned OP_CYCLES = 20000
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] fw_ctrl,
  input wire logic       fw_ctrl_wr,
  input wire logic       par_mode,
  input wire logic       code_rd,
  input wire logic [7:0] code_data,
  input wire logic       code_refused,
  input wire logic       busy,
  input wire logic       op_done,
  input wire logic [7:0] power_up_config_byte,
  input wire logic       boot_status,
  input wire logic [7:0] boot_vector
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  int unsigned run; // Cycles spent busy in the current operation.
  logic [2:0]  age; // Edges since reset release, saturating at seven.
  // Counts busy time and the settling time after reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run <= 0;
      age <= 3'h0;
    end else begin
      run <= busy ? run + 1 : 0;
      age <= (age == 3'h7) ? age : age + 3'h1;
    end
  end
  // A timed program or erase request taken while idle.
  sequence s_start;
    fw_ctrl_wr && !busy && fw_ctrl[3:0] inside {[4'h2:4'h6]};
  endsequence
  // The completion pulse lasts exactly one cycle.
  sequence s_pulse;
    op_done ##1 !op_done;
  endsequence
  busy_rise_a: assert property (s_start |=> busy) else $error("busy did not rise");
  done_idle_a: assert property (op_done |-> !busy) else $error("busy at done");
  done_after_a: assert property (op_done |-> $past(busy)) else $error("done without busy");
  done_pulse_a: assert property (op_done |-> s_pulse) else $error("done too long");
  op_time_a: assert property (run <= OP_CYCLES) else $error("operation too long");
  refused_data_a: assert property (code_refused |-> code_data == 8'h00)
    else $error("refused read leaks data");
  par_refuse_a: assert property (code_rd && par_mode |=> ##[0:1] code_refused)
    else $error("read not refused in parallel mode");
  cfg_fixed_a: assert property (age == 3'h7 |-> $stable(power_up_config_byte)
    && $stable(boot_status) && $stable(boot_vector)) else $error("config changed");
endmodule : cfp_ctrl_assertions
bind cfp_ctrl cfp_ctrl_assertions #(.OP_CYCLES(OP_CYCLES)) u_chk (
  .clk, .rst_n, .fw_ctrl, .fw_ctrl_wr, .par_mode, .code_rd, .code_data, .code_refused,
  .busy, .op_done, .power_up_config_byte, .boot_status, .boot_vector
);

// *** verification/code_flash_program_erase_control_test.sv ***
/*
  Self-checking bench for the code flash controller.
  Assumes the serial programmer model and the bound checker.
*/
`timescale 1ns/1ps
module code_flash_program_erase_control_test;
  localparam int unsigned OPC = 1200; // Shortened operation time.
  logic        clk, rst_n, fw_ctrl_wr, par_mode, sclk, sdata_in, frame_n;
  logic        code_rd, code_refused, busy, op_done, boot_status;
  logic [7:0]  fw_ctrl, fw_data, fw_addr_hi, fw_addr_lo, code_data;
  logic [7:0]  power_up_config_byte, boot_vector;
  logic [9:0]  code_addr;
  logic [31:0] crc_result;
  int          n_errors, checked, n;
  cfp_ctrl #(.OP_CYCLES(OPC)) dut (
    .clk, .rst_n, .fw_ctrl, .fw_ctrl_wr, .fw_data, .fw_addr_hi, .fw_addr_lo, .par_mode,
    .sclk, .sdata_in, .frame_n, .code_addr, .code_rd, .code_data, .code_refused, .busy,
    .op_done, .crc_result, .power_up_config_byte, .boot_status, .boot_vector
  );
  cfp_ser_prog prog (.sclk, .sdata_in, .frame_n);
  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("Checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  // Compares one result value.
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // Writes the firmware registers and pulses the control strobe for one cycle.
  task automatic op(input cfp_pkg::cfp_op_e c, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    fw_ctrl    <= {4'h0, c};
    fw_addr_hi <= {6'h00, a[9:8]};
    fw_addr_lo <= a[7:0];
    fw_data    <= d;
    fw_ctrl_wr <= 1'b1;
    @(posedge clk);
    fw_ctrl_wr <= 1'b0;
  endtask : op
  // Waits for the completion pulse under a bound; n holds the cycles waited.
  task automatic done;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (op_done !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      n_errors++;
      $display("Error op_done expected 1 seen %b", op_done);
      test_done;
    end
  endtask : done
  // Issues an operation and waits for it to finish.
  task automatic go(input cfp_pkg::cfp_op_e c, input logic [9:0] a);
    op(c, a, 8'h00);
    done;
  endtask : go
  // Programs a single byte through the page buffer.
  task automatic prog1(input logic [9:0] a, input logic [7:0] d);
    op(cfp_pkg::CFP_OP_LOAD, a, d);
    go(cfp_pkg::CFP_OP_PROG_PAGE, a);
  endtask : prog1
  // Reads one code byte and checks data and refusal once the answer has landed.
  task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic r);
    @(posedge clk);
    code_addr <= a;
    code_rd   <= 1'b1;
    @(posedge clk);
    code_rd <= 1'b0;
    @(posedge clk);
    #1;
    chk("code_refused", 32'(r), 32'(code_refused));
    chk("code_data", 32'(e), 32'(code_data));
  endtask : rd
  // Reference CRC over a run of erased bytes, MSB first, no final inversion.
  function automatic logic [31:0] crc_ff(input int bytes);
    logic [31:0] c;
    c = cfp_pkg::CRC_SEED;
    for (int i = 0; i < bytes * 8; i++) begin
      c = {c[30:0], 1'b0} ^ (c[31] ? 32'h0 : cfp_pkg::CRC_POLY);
    end
    return c;
  endfunction : crc_ff
  // Full page program after a chip erase; neighbours stay erased.
  task automatic t_prog;
    go(cfp_pkg::CFP_OP_ERASE_CHIP, 10'h000);
    for (int i = 0; i < 16; i++) begin
      op(cfp_pkg::CFP_OP_LOAD, 10'(16 + i), 8'(i) ^ 8'ha0);
    end
    go(cfp_pkg::CFP_OP_PROG_PAGE, 10'h010);
    rd(10'h00f, 8'hff, 1'b0);
    rd(10'h010, 8'ha0, 1'b0);
    rd(10'h01f, 8'haf, 1'b0);
    rd(10'h020, 8'hff, 1'b0);
  endtask : t_prog
  // Sector, byte and page erase each clear only their own span.
  task automatic t_erase;
    prog1(10'h0ff, 8'h5a);
    prog1(10'h100, 8'h3c);
    go(cfp_pkg::CFP_OP_ERASE_SECT, 10'h100);
    rd(10'h100, 8'hff, 1'b0);
    rd(10'h0ff, 8'h5a, 1'b0);
    go(cfp_pkg::CFP_OP_ERASE_BYTE, 10'h015);
    rd(10'h015, 8'hff, 1'b0);
    rd(10'h014, 8'ha4, 1'b0);
    go(cfp_pkg::CFP_OP_ERASE_PAGE, 10'h01a);
    rd(10'h01f, 8'hff, 1'b0);
    rd(10'h0ff, 8'h5a, 1'b0);
  endtask : t_erase
  // Requests during an operation are ignored; read requests never start one.
  task automatic t_busy;
    op(cfp_pkg::CFP_OP_READ, 10'h0ff, 8'h00);
    @(posedge clk);
    #1;
    chk("busy", 32'h0, 32'(busy));
    op(cfp_pkg::CFP_OP_ERASE_BYTE, 10'h0ff, 8'h00);
    op(cfp_pkg::CFP_OP_LOAD, 10'h0ff, 8'h00);
    op(cfp_pkg::CFP_OP_PROG_PAGE, 10'h0ff, 8'h00);
    #1;
    chk("busy", 32'h1, 32'(busy));
    done;
    chk("op_cycles", OPC - 4, n);
    rd(10'h0ff, 8'hff, 1'b0);
  endtask : t_busy
  // Sector and whole-array CRC over an erased array.
  task automatic t_crc;
    go(cfp_pkg::CFP_OP_ERASE_CHIP, 10'h000);
    go(cfp_pkg::CFP_OP_CRC_SECT, 10'h100);
    chk("crc_result", crc_ff(256), crc_result);
    go(cfp_pkg::CFP_OP_CRC_ALL, 10'h000);
    chk("crc_result", crc_ff(1024), crc_result);
  endtask : t_crc
  // Per-sector security, parallel mode refusal, fixed power-up configuration.
  task automatic t_sec;
    prog1(10'h1ff, 8'h77);
    go(cfp_pkg::CFP_OP_PROG_CFG, 10'h005);
    rd(10'h1ff, 8'h00, 1'b1);
    rd(10'h200, 8'hff, 1'b0);
    go(cfp_pkg::CFP_OP_ERASE_CFG, 10'h005);
    rd(10'h1ff, 8'h77, 1'b0);
    par_mode <= 1'b1;
    rd(10'h1ff, 8'h00, 1'b1);
    par_mode <= 1'b0;
    op(cfp_pkg::CFP_OP_PROG_CFG, 10'h000, 8'h3c);
    done;
    chk("power_up_config_byte", 32'hff, 32'(power_up_config_byte));
    chk("boot_status", 32'h1, 32'(boot_status));
    chk("boot_vector", 32'hff, 32'(boot_vector));
  endtask : t_sec
  // Load and page program arriving over the serial port.
  task automatic t_ser;
    prog.send('{cfp_pkg::CFP_OP_LOAD, 10'h080, 8'h81});
    prog.send('{cfp_pkg::CFP_OP_PROG_PAGE, 10'h080, 8'h00});
    done;
    rd(10'h080, 8'h81, 1'b0);
  endtask : t_ser
  // Reset, then every scenario in turn.
  initial begin
    n_errors   = 0;
    checked    = 0;
    rst_n      = 1'b0;
    fw_ctrl    = 8'h00;
    fw_ctrl_wr = 1'b0;
    fw_data    = 8'h00;
    fw_addr_hi = 8'h00;
    fw_addr_lo = 8'h00;
    par_mode   = 1'b0;
    code_addr  = 10'h000;
    code_rd    = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    t_prog;
    t_erase;
    t_busy;
    t_crc;
    t_sec;
    t_ser;
    test_done;
  end
endmodule : code_flash_program_erase_control_test
